// [logic/rtpb_bank.sv]
// Purpose: Holding register bank for restart and thermal settings
// Assumes: Master keeps strobes one cycle long and never both at once
// Notes:   Out-of-range writes leave the stored value untouched
//
// How it works
// - Restart mode takes codes 0 to 4 only
// - Under-voltage allowance takes 3 to 250 tenths of a second
// - Restart delay takes 3 to 1000 tenths of a second
// - Power-fail alarm enable takes codes 0, 1 or 2
// - Both under-voltage restart count selectors take 0 or 1
// - Phase loss detection takes 0 or 1
// - Threshold is hi/lo word pair, 0 to 40000 in 0.01 Hz
// - Trip retry selector takes codes 0 to 4
// - Overvoltage/overcurrent retry count takes 1 to 3
// - Trip retry wait takes 3 to 1000 tenths of a second
// - Three thermal levels each take 200 to 1000
// - Two thermal curve selectors take 0, 1 or 2
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps

module rtpb_bank
  import rtpb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  output logic             wr_reject,
  output logic      [2:0]  restart_mode_select,
  output logic      [7:0]  undervoltage_allow_time,
  output logic      [9:0]  restart_delay_time,
  output logic      [1:0]  power_fail_alarm_enable,
  output logic             power_fail_restart_count,
  output logic             phase_loss_detect_enable,
  output logic      [15:0] restart_freq_threshold,
  output logic      [2:0]  trip_retry_select,
  output logic             undervoltage_retry_select,
  output logic      [1:0]  overstress_retry_count,
  output logic      [9:0]  trip_retry_wait,
  output logic      [9:0]  thermal_level_motor1,
  output logic      [1:0]  thermal_curve_motor1,
  output logic      [9:0]  thermal_level_motor2,
  output logic      [1:0]  thermal_curve_motor2,
  output logic      [9:0]  thermal_level_motor3
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic in_range(input logic [15:0] v,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [15:0] mode_reg;
  logic [15:0] uv_reg;
  logic [15:0] delay_reg;
  logic [15:0] pfa_reg;
  logic [15:0] pfc_reg;
  logic [15:0] pl_reg;
  logic [15:0] thi_reg;
  logic [15:0] tlo_reg;
  logic [15:0] thi_pend_reg;
  logic [15:0] tr_reg;
  logic [15:0] uvr_reg;
  logic [15:0] os_reg;
  logic [15:0] wait_reg;
  logic [15:0] lvl1_reg;
  logic [15:0] crv1_reg;
  logic [15:0] lvl2_reg;
  logic [15:0] crv2_reg;
  logic [15:0] lvl3_reg;
  logic [31:0] thr_eff_reg;
  logic [15:0] rdata_reg;
  logic        rej_reg;
  rtpb_pair_t  pair_reg;
  rtpb_pair_t  pair_next;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire sel_mode  = (addr == RTPB_ADDR_RESTART_MODE);
  wire sel_uv    = (addr == RTPB_ADDR_UV_ALLOW);
  wire sel_delay = (addr == RTPB_ADDR_RESTART_DELAY);
  wire sel_pfa   = (addr == RTPB_ADDR_PF_ALARM);
  wire sel_pfc   = (addr == RTPB_ADDR_PF_COUNT);
  wire sel_pl    = (addr == RTPB_ADDR_PHASE_LOSS);
  wire sel_thi   = (addr == RTPB_ADDR_THRESH_HI);
  wire sel_tlo   = (addr == RTPB_ADDR_THRESH_LO);
  wire sel_tr    = (addr == RTPB_ADDR_TRIP_RETRY);
  wire sel_uvr   = (addr == RTPB_ADDR_UV_RETRY);
  wire sel_os    = (addr == RTPB_ADDR_OS_COUNT);
  wire sel_wait  = (addr == RTPB_ADDR_RETRY_WAIT);
  wire sel_lvl1  = (addr == RTPB_ADDR_THERM_LVL1);
  wire sel_crv1  = (addr == RTPB_ADDR_THERM_CRV1);
  wire sel_lvl2  = (addr == RTPB_ADDR_THERM_LVL2);
  wire sel_crv2  = (addr == RTPB_ADDR_THERM_CRV2);
  wire sel_lvl3  = (addr == RTPB_ADDR_THERM_LVL3);
  wire sel_any   = sel_mode | sel_uv | sel_delay | sel_pfa | sel_pfc |
                   sel_pl | sel_thi | sel_tlo | sel_tr | sel_uvr |
                   sel_os | sel_wait | sel_lvl1 | sel_crv1 | sel_lvl2 |
                   sel_crv2 | sel_lvl3;

  // ----------------------------------------------------------------
  // Range checks
  // ----------------------------------------------------------------
  wire ok_mode  = in_range(wdata, RTPB_RST_ZERO, RTPB_MODE_MAX);
  wire ok_uv    = in_range(wdata, RTPB_UV_MIN, RTPB_UV_MAX);
  wire ok_wait  = in_range(wdata, RTPB_WAIT_MIN, RTPB_WAIT_MAX);
  wire ok_tri   = in_range(wdata, RTPB_RST_ZERO, RTPB_TRI_MAX);
  wire ok_bin   = in_range(wdata, RTPB_RST_ZERO, RTPB_BIN_MAX);
  wire ok_os    = in_range(wdata, RTPB_OS_MIN, RTPB_OS_MAX);
  wire ok_therm = in_range(wdata, RTPB_THERM_MIN, RTPB_THERM_MAX);
  wire [31:0] thr_pair = {thi_pend_reg, wdata};
  wire ok_thr   = (thr_pair <= RTPB_THRESH_MAX);

  // Word that makes a completed pair legal; high word alone is held
  wire ok_thi   = (wdata <= RTPB_THRESH_MAX[31:16]);

  wire w_mode  = wr && sel_mode  && ok_mode;
  wire w_uv    = wr && sel_uv    && ok_uv;
  wire w_delay = wr && sel_delay && ok_wait;
  wire w_pfa   = wr && sel_pfa   && ok_tri;
  wire w_pfc   = wr && sel_pfc   && ok_bin;
  wire w_pl    = wr && sel_pl    && ok_bin;
  wire w_thi   = wr && sel_thi   && ok_thi;
  wire w_tlo   = wr && sel_tlo   && ok_thr &&
                 (pair_reg == RTPB_PAIR_HI_SET);
  wire w_tr    = wr && sel_tr    && ok_mode;
  wire w_uvr   = wr && sel_uvr   && ok_bin;
  wire w_os    = wr && sel_os    && ok_os;
  wire w_wait  = wr && sel_wait  && ok_wait;
  wire w_lvl1  = wr && sel_lvl1  && ok_therm;
  wire w_crv1  = wr && sel_crv1  && ok_tri;
  wire w_lvl2  = wr && sel_lvl2  && ok_therm;
  wire w_crv2  = wr && sel_crv2  && ok_tri;
  wire w_lvl3  = wr && sel_lvl3  && ok_therm;

  wire any_ok = w_mode | w_uv | w_delay | w_pfa | w_pfc | w_pl |
                w_thi | w_tlo | w_tr | w_uvr | w_os | w_wait |
                w_lvl1 | w_crv1 | w_lvl2 | w_crv2 | w_lvl3;

  // Unmapped addresses also count as refused
  wire rej_now = wr && !any_ok;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [15:0] rd_mux =
      sel_mode  ? mode_reg  : sel_uv   ? uv_reg   :
      sel_delay ? delay_reg : sel_pfa  ? pfa_reg  :
      sel_pfc   ? pfc_reg   : sel_pl   ? pl_reg   :
      sel_thi   ? thi_reg   : sel_tlo  ? tlo_reg  :
      sel_tr    ? tr_reg    : sel_uvr  ? uvr_reg  :
      sel_os    ? os_reg    : sel_wait ? wait_reg :
      sel_lvl1  ? lvl1_reg  : sel_crv1 ? crv1_reg :
      sel_lvl2  ? lvl2_reg  : sel_crv2 ? crv2_reg :
      sel_lvl3  ? lvl3_reg  : RTPB_RST_ZERO;

  // ----------------------------------------------------------------
  // Threshold pairing
  // ----------------------------------------------------------------
  always_comb begin
    pair_next = pair_reg;
    case (pair_reg)
      RTPB_PAIR_IDLE:   if (w_thi) pair_next = RTPB_PAIR_HI_SET;
      RTPB_PAIR_HI_SET: if (w_tlo) pair_next = RTPB_PAIR_IDLE;
      default:          pair_next = RTPB_PAIR_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_reg     <= RTPB_RST_MODE;
      uv_reg       <= RTPB_RST_UV;
      delay_reg    <= RTPB_RST_WAIT;
      pfa_reg      <= RTPB_RST_ZERO;
      pfc_reg      <= RTPB_RST_ZERO;
      pl_reg       <= RTPB_RST_ZERO;
      thi_reg      <= RTPB_RST_ZERO;
      tlo_reg      <= RTPB_RST_ZERO;
      thi_pend_reg <= RTPB_RST_ZERO;
      tr_reg       <= RTPB_RST_MODE;
      uvr_reg      <= RTPB_RST_ZERO;
      os_reg       <= RTPB_RST_OS;
      wait_reg     <= RTPB_RST_WAIT;
      lvl1_reg     <= RTPB_RST_THERM;
      crv1_reg     <= RTPB_RST_CURVE;
      lvl2_reg     <= RTPB_RST_THERM;
      crv2_reg     <= RTPB_RST_CURVE;
      lvl3_reg     <= RTPB_RST_THERM;
      thr_eff_reg  <= {RTPB_RST_ZERO, RTPB_RST_ZERO};
      pair_reg     <= RTPB_PAIR_IDLE;
      rdata_reg    <= RTPB_RST_ZERO;
      rej_reg      <= 1'b0;
    end else begin
      if (w_mode)  mode_reg  <= wdata;
      if (w_uv)    uv_reg    <= wdata;
      if (w_delay) delay_reg <= wdata;
      if (w_pfa)   pfa_reg   <= wdata;
      if (w_pfc)   pfc_reg   <= wdata;
      if (w_pl)    pl_reg    <= wdata;
      if (w_thi)   thi_pend_reg <= wdata;
      if (w_tlo) begin
        thi_reg     <= thi_pend_reg;
        tlo_reg     <= wdata;
        thr_eff_reg <= thr_pair;
      end
      if (w_tr)    tr_reg    <= wdata;
      if (w_uvr)   uvr_reg   <= wdata;
      if (w_os)    os_reg    <= wdata;
      if (w_wait)  wait_reg  <= wdata;
      if (w_lvl1)  lvl1_reg  <= wdata;
      if (w_crv1)  crv1_reg  <= wdata;
      if (w_lvl2)  lvl2_reg  <= wdata;
      if (w_crv2)  crv2_reg  <= wdata;
      if (w_lvl3)  lvl3_reg  <= wdata;
      pair_reg  <= pair_next;
      rdata_reg <= rd ? rd_mux : RTPB_RST_ZERO;
      rej_reg   <= rej_now;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata                     = rdata_reg;
  assign wr_reject                 = rej_reg;
  assign restart_mode_select       = mode_reg[2:0];
  assign undervoltage_allow_time   = uv_reg[7:0];
  assign restart_delay_time        = delay_reg[9:0];
  assign power_fail_alarm_enable   = pfa_reg[1:0];
  assign power_fail_restart_count  = pfc_reg[0];
  assign phase_loss_detect_enable  = pl_reg[0];
  // Combined value fits 16 bits since the maximum is 40000
  assign restart_freq_threshold    = thr_eff_reg[15:0];
  assign trip_retry_select         = tr_reg[2:0];
  assign undervoltage_retry_select = uvr_reg[0];
  assign overstress_retry_count    = os_reg[1:0];
  assign trip_retry_wait           = wait_reg[9:0];
  assign thermal_level_motor1      = lvl1_reg[9:0];
  assign thermal_curve_motor1      = crv1_reg[1:0];
  assign thermal_level_motor2      = lvl2_reg[9:0];
  assign thermal_curve_motor2      = crv2_reg[1:0];
  assign thermal_level_motor3      = lvl3_reg[9:0];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_mode_range;
    @(posedge clk) disable iff (!rst_b)
      mode_reg <= RTPB_MODE_MAX;
  endproperty
  a_mode_range: assert property (p_mode_range)
    else $error("restart mode out of range");

  property p_uv_range;
    @(posedge clk) disable iff (!rst_b)
      uv_reg >= RTPB_UV_MIN && uv_reg <= RTPB_UV_MAX;
  endproperty
  a_uv_range: assert property (p_uv_range)
    else $error("undervoltage time out of range");

  property p_delay_bad_hold;
    @(posedge clk) disable iff (!rst_b)
      (wr && sel_delay && !ok_wait) |=> $stable(delay_reg);
  endproperty
  a_delay_bad_hold: assert property (p_delay_bad_hold)
    else $error("restart delay took illegal value");

  property p_pfa_range;
    @(posedge clk) disable iff (!rst_b)
      pfa_reg <= RTPB_TRI_MAX;
  endproperty
  a_pfa_range: assert property (p_pfa_range)
    else $error("alarm enable out of range");

  property p_pfc_write;
    @(posedge clk) disable iff (!rst_b)
      (wr && sel_pfc && wdata <= RTPB_BIN_MAX)
        |=> pfc_reg == $past(wdata);
  endproperty
  a_pfc_write: assert property (p_pfc_write)
    else $error("restart count write lost");

  property p_os_range;
    @(posedge clk) disable iff (!rst_b)
      os_reg >= RTPB_OS_MIN && os_reg <= RTPB_OS_MAX;
  endproperty
  a_os_range: assert property (p_os_range)
    else $error("retry count out of range");

  sequence s_thr_hi;
    wr && sel_thi && ok_thi;
  endsequence
  sequence s_thr_lo;
    wr && sel_tlo && ok_thr;
  endsequence
  property p_thr_pair;
    @(posedge clk) disable iff (!rst_b)
      (s_thr_hi ##1 (!wr)[*1] ##1 s_thr_lo)
        |=> thr_eff_reg == {$past(wdata, 3), $past(wdata)};
  endproperty
  a_thr_pair: assert property (p_thr_pair)
    else $error("threshold pair not applied");

  property p_lo_alone;
    @(posedge clk) disable iff (!rst_b)
      (wr && sel_tlo && pair_reg == RTPB_PAIR_IDLE)
        |=> $stable(thr_eff_reg);
  endproperty
  a_lo_alone: assert property (p_lo_alone)
    else $error("threshold changed without high word");

  property p_therm_range;
    @(posedge clk) disable iff (!rst_b)
      lvl3_reg >= RTPB_THERM_MIN && lvl3_reg <= RTPB_THERM_MAX;
  endproperty
  a_therm_range: assert property (p_therm_range)
    else $error("thermal level out of range");

  property p_reject_flag;
    @(posedge clk) disable iff (!rst_b)
      (wr && !any_ok) |=> wr_reject ##1 (!wr_reject || $past(wr));
  endproperty
  a_reject_flag: assert property (p_reject_flag)
    else $error("refused write not flagged");

  property p_hole_zero;
    @(posedge clk) disable iff (!rst_b)
      (rd && !sel_any) |=> rdata == 16'h0000;
  endproperty
  a_hole_zero: assert property (p_hole_zero)
    else $error("unmapped read not zero");

endmodule

// [logic/rtpb_pkg.sv]
// Purpose: Constants for the restart and thermal setting bank
// Assumes: 16-bit holding registers at word addresses
// Notes:   Reset values are plain defaults inside each legal range
package rtpb_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] RTPB_ADDR_RESTART_MODE   = 16'h1301;
  localparam logic [15:0] RTPB_ADDR_UV_ALLOW       = 16'h1302;
  localparam logic [15:0] RTPB_ADDR_RESTART_DELAY  = 16'h1303;
  localparam logic [15:0] RTPB_ADDR_PF_ALARM       = 16'h1304;
  localparam logic [15:0] RTPB_ADDR_PF_COUNT       = 16'h1305;
  localparam logic [15:0] RTPB_ADDR_PHASE_LOSS     = 16'h1306;
  localparam logic [15:0] RTPB_ADDR_THRESH_HI      = 16'h1307;
  localparam logic [15:0] RTPB_ADDR_THRESH_LO      = 16'h1308;
  localparam logic [15:0] RTPB_ADDR_TRIP_RETRY     = 16'h1309;
  localparam logic [15:0] RTPB_ADDR_UV_RETRY       = 16'h130a;
  localparam logic [15:0] RTPB_ADDR_OS_COUNT       = 16'h130b;
  localparam logic [15:0] RTPB_ADDR_RETRY_WAIT     = 16'h130c;
  localparam logic [15:0] RTPB_ADDR_THERM_LVL1     = 16'h130d;
  localparam logic [15:0] RTPB_ADDR_THERM_CRV1     = 16'h130e;
  localparam logic [15:0] RTPB_ADDR_THERM_LVL2     = 16'h230c;
  localparam logic [15:0] RTPB_ADDR_THERM_CRV2     = 16'h230d;
  localparam logic [15:0] RTPB_ADDR_THERM_LVL3     = 16'h330c;

  // ----------------------------------------------------------------
  // Legal ranges
  // ----------------------------------------------------------------
  localparam logic [15:0] RTPB_MODE_MAX      = 16'h0004;
  localparam logic [15:0] RTPB_UV_MIN        = 16'h0003;
  localparam logic [15:0] RTPB_UV_MAX        = 16'h00fa;
  localparam logic [15:0] RTPB_WAIT_MIN      = 16'h0003;
  localparam logic [15:0] RTPB_WAIT_MAX      = 16'h03e8;
  localparam logic [15:0] RTPB_TRI_MAX       = 16'h0002;
  localparam logic [15:0] RTPB_BIN_MAX       = 16'h0001;
  localparam logic [31:0] RTPB_THRESH_MAX    = 32'h00009c40;
  localparam logic [15:0] RTPB_OS_MIN        = 16'h0001;
  localparam logic [15:0] RTPB_OS_MAX        = 16'h0003;
  localparam logic [15:0] RTPB_THERM_MIN     = 16'h00c8;
  localparam logic [15:0] RTPB_THERM_MAX     = 16'h03e8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RTPB_RST_MODE      = 16'h0000;
  localparam logic [15:0] RTPB_RST_UV        = 16'h000a;
  localparam logic [15:0] RTPB_RST_WAIT      = 16'h000a;
  localparam logic [15:0] RTPB_RST_ZERO      = 16'h0000;
  localparam logic [15:0] RTPB_RST_OS        = 16'h0003;
  localparam logic [15:0] RTPB_RST_THERM     = 16'h03e8;
  localparam logic [15:0] RTPB_RST_CURVE     = 16'h0001;

  // ----------------------------------------------------------------
  // Threshold pairing states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    RTPB_PAIR_IDLE   = 1'b0,
    RTPB_PAIR_HI_SET = 1'b1
  } rtpb_pair_t;

endpackage

// [sim/restart_thermal_param_bank_test.sv]
// Purpose: Self-checking bench for the restart and thermal setting bank
// Assumes: Reads answer one cycle after the strobe
// Notes:   Shadow copy of every register predicts reads and ports
`timescale 1ns/100ps

module restart_thermal_param_bank_test
  import rtpb_pkg::*;
;

  logic        clk;
  logic        rst_b;
  logic [15:0] addr, wdata, rdata;
  logic        wr, rd, wr_reject;
  logic [2:0]  mode_o, trip_o;
  logic [7:0]  uv_o;
  logic [9:0]  delay_o, wait_o, lvl1_o, lvl2_o, lvl3_o;
  logic [1:0]  alarm_o, os_o, crv1_o, crv2_o;
  logic        pfc_o, phase_o, uvr_o;
  logic [15:0] thr_o;
  int          err_count = 0;
  int          checks    = 0;
  logic [31:0] seed      = 32'h5547;

  logic [15:0] t_adr [17] = '{16'h1301, 16'h1302, 16'h1303, 16'h1304,
    16'h1305, 16'h1306, 16'h1307, 16'h1308, 16'h1309, 16'h130a, 16'h130b,
    16'h130c, 16'h130d, 16'h130e, 16'h230c, 16'h230d, 16'h330c};
  logic [15:0] t_min [17] = '{16'h0000, 16'h0003, 16'h0003, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001,
    16'h0003, 16'h00c8, 16'h0000, 16'h00c8, 16'h0000, 16'h00c8};
  logic [15:0] t_max [17] = '{16'h0004, 16'h00fa, 16'h03e8, 16'h0002,
    16'h0001, 16'h0001, 16'h0000, 16'h9c40, 16'h0004, 16'h0001, 16'h0003,
    16'h03e8, 16'h03e8, 16'h0002, 16'h03e8, 16'h0002, 16'h03e8};
  logic [15:0] t_rst [17] = '{16'h0000, 16'h000a, 16'h000a, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0003,
    16'h000a, 16'h03e8, 16'h0001, 16'h03e8, 16'h0001, 16'h03e8};
  logic [15:0] shadow [17];

  initial clk = 1'b0;
  always #2 clk = ~clk;

  rtpb_bank uut (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .wr_reject(wr_reject), .restart_mode_select(mode_o),
    .undervoltage_allow_time(uv_o), .restart_delay_time(delay_o),
    .power_fail_alarm_enable(alarm_o), .power_fail_restart_count(pfc_o),
    .phase_loss_detect_enable(phase_o), .restart_freq_threshold(thr_o),
    .trip_retry_select(trip_o), .undervoltage_retry_select(uvr_o),
    .overstress_retry_count(os_o), .trip_retry_wait(wait_o),
    .thermal_level_motor1(lvl1_o), .thermal_curve_motor1(crv1_o),
    .thermal_level_motor2(lvl2_o), .thermal_curve_motor2(crv2_o),
    .thermal_level_motor3(lvl3_o));

  rtpb_net_master net (
    .clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .wr_reject(wr_reject));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [15:0] port_of(input int i);
    case (i)
      0: return 16'(mode_o);
      1: return 16'(uv_o);
      2: return 16'(delay_o);
      3: return 16'(alarm_o);
      4: return 16'(pfc_o);
      5: return 16'(phase_o);
      6: return 16'h0000;
      7: return thr_o;
      8: return 16'(trip_o);
      9: return 16'(uvr_o);
      10: return 16'(os_o);
      11: return 16'(wait_o);
      12: return 16'(lvl1_o);
      13: return 16'(crv1_o);
      14: return 16'(lvl2_o);
      15: return 16'(crv2_o);
      default: return 16'(lvl3_o);
    endcase
  endfunction

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic check_reg(input int i);
    logic [15:0] d;
    net.read(t_adr[i], d);
    cmp(d, shadow[i], "read back");
    cmp(port_of(i), shadow[i], "setting port");
  endtask

  task automatic try_write(input int i, input logic [15:0] v);
    logic rej;
    logic ok;
    ok = (v >= t_min[i]) && (v <= t_max[i]);
    net.write(t_adr[i], v, rej);
    if (ok) shadow[i] = v;
    cmp(16'(rej), 16'(!ok), "write refusal");
    check_reg(i);
  endtask

  // Both edges of the range, one step outside, then random values
  task automatic sweep(input int i);
    try_write(i, t_max[i]);
    try_write(i, t_max[i] + 16'h0001);
    try_write(i, t_min[i]);
    if (t_min[i] != 16'h0000) try_write(i, t_min[i] - 16'h0001);
    repeat (4) begin
      seed = lfsr(seed);
      try_write(i, t_min[i] + 16'(seed % (t_max[i] - t_min[i] + 1)));
      seed = lfsr(seed);
      try_write(i, seed[15:0]);
    end
  endtask

  task automatic reset_check;
    for (int i = 0; i < 17; i++) begin
      shadow[i] = t_rst[i];
      check_reg(i);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    close_out();
  end

  initial begin
    logic        rh, rl, rej;
    logic [15:0] d, v;
    logic [15:0] holes [4];
    holes = '{16'h1300, 16'h130f, 16'h230e, 16'h2fff};
    rst_b = 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    reset_check();
    sweep(0);
    sweep(1);
    sweep(2);
    sweep(3);
    sweep(4);
    sweep(5);
    sweep(8);
    sweep(9);
    sweep(10);
    sweep(11);
    sweep(12);
    sweep(13);
    sweep(14);
    sweep(15);
    sweep(16);
    // Low word with no high word before it must not commit
    net.write(RTPB_ADDR_THRESH_LO, 16'h0005, rej);
    cmp(16'(rej), 16'h0001, "lone low word");
    check_reg(7);
    net.write_pair(16'h0000, 16'h9c40, rh, rl);
    shadow[7] = 16'h9c40;
    cmp(16'({rh, rl}), 16'h0000, "threshold at top");
    check_reg(7);
    net.write_pair(16'h0000, 16'h9c41, rh, rl);
    cmp(16'(rl), 16'h0001, "threshold above top");
    // Refused high word keeps the earlier pending one, so low commits
    net.write_pair(16'h0001, 16'h0000, rh, rl);
    shadow[7] = 16'h0000;
    cmp(16'({rh, rl}), 16'h0002, "high word overflow");
    check_reg(6);
    check_reg(7);
    repeat (4) begin
      seed = lfsr(seed);
      v = 16'(seed % 40001);
      net.write_pair(16'h0000, v, rh, rl);
      shadow[7] = v;
      cmp(16'({rh, rl}), 16'h0000, "random threshold");
      check_reg(7);
    end
    @(posedge clk);
    #1;
    cmp(rdata, 16'h0000, "read data after its cycle");
    foreach (holes[k]) begin
      net.write(holes[k], 16'h0001, rej);
      cmp(16'(rej), 16'h0001, "reserved write");
      net.read(holes[k], d);
      cmp(d, 16'h0000, "reserved read");
    end
    check_reg(0);
    // Second reset in mid-run must restore every default
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    reset_check();
    close_out();
  end

endmodule

// [sim/rtpb_net_master.sv]
// Purpose: Network master model for the holding register port
// Assumes: One-cycle strobes, answer sampled in the following cycle
// Notes:   Released address and data lines are inverted, not held
`timescale 1ns/100ps

module rtpb_net_master
  import rtpb_pkg::*;
(
  input  wire logic        clk,
  output logic      [15:0] addr,
  output logic      [15:0] wdata,
  output logic             wr,
  output logic             rd,
  input  wire logic [15:0] rdata,
  input  wire logic        wr_reject
);

  initial begin
    addr  = 16'h0000;
    wdata = 16'h0000;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // Stale values on a released bus would hide decode slips
  task automatic release_bus;
    addr  <= ~addr;
    wdata <= ~wdata;
  endtask

  task automatic write(input logic [15:0] a, input logic [15:0] d,
                       output logic rej);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    release_bus();
    #1;
    rej = wr_reject;
  endtask

  task automatic read(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    release_bus();
    #1;
    d = rdata;
  endtask

  // High word always goes first, then the low word commits both
  task automatic write_pair(input logic [15:0] hi, input logic [15:0] lo,
                            output logic rej_hi, output logic rej_lo);
    write(RTPB_ADDR_THRESH_HI, hi, rej_hi);
    write(RTPB_ADDR_THRESH_LO, lo, rej_lo);
  endtask

endmodule
